/* design/adt_counter.sv */
// Down counter with load, stop, single-pass halt and auto reload.
// Assumes a synchronised reset and control from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module adt_counter #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_ni,
  // Control
  input  wire logic         start_i,
  input  wire logic         stop_i,
  input  wire logic         single_i,
  input  wire logic [W-1:0] value_i,
  // Status
  output logic              run_o,
  output logic              tc_o,
  output logic [W-1:0]      count_o
);
  if (W < 2) begin : g_bad_width
    $error("adt_counter: W must be at least 2");
  end

  logic         run_d;
  logic [W-1:0] cnt_d;

  assign tc_o = run_o && (count_o == W'(1));

  always_comb begin
    run_d = run_o;
    cnt_d = count_o;
    if (stop_i) begin
      run_d = 1'b0;
    end else if (start_i) begin
      run_d = 1'b1;
      cnt_d = value_i;
    end else if (run_o) begin
      if (tc_o) begin
        if (single_i) begin
          run_d = 1'b0;
        end else begin
          cnt_d = value_i;
        end
      end else begin
        cnt_d = count_o - W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      run_o   <= 1'b0;
      count_o <= '0;
    end else begin
      run_o   <= run_d;
      count_o <= cnt_d;
    end
  end

  restart_load_a: assert property (
    @(posedge clk_i) disable iff (!rst_ni)
    (start_i && !stop_i) |=> (run_o && count_o == $past(value_i)))
    else $error("restart did not load the programmed value");

  single_halt_a: assert property (
    @(posedge clk_i) disable iff (!rst_ni)
    (tc_o && single_i && !start_i) |=> !run_o)
    else $error("single-pass counter kept running after terminal count");
endmodule : adt_counter
`default_nettype wire

/* design/adt_pkg.sv */
// Constants for the alternating dual timer: register map, fields, resets.
// Assumes byte addresses on an 8-bit register port with 8-bit data.
package adt_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned SHORT_W = 8;
  localparam int unsigned LONG_W  = 16;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADR_SHORT_CTRL  = 8'h00;
  localparam logic [7:0] ADR_SHARED_CTRL = 8'h01;
  localparam logic [7:0] ADR_LONG_CTRL   = 8'h02;
  localparam logic [7:0] ADR_SRL_LO      = 8'h04;
  localparam logic [7:0] ADR_SRL_HI      = 8'h05;
  localparam logic [7:0] ADR_LRL_LO      = 8'h06;
  localparam logic [7:0] ADR_LRL_HI      = 8'h07;
  localparam logic [7:0] ADR_IRQ_STATUS  = 8'h08;
  localparam logic [7:0] ADR_IRQ_CLEAR   = 8'h09;
  localparam logic [7:0] ADR_IRQ_ENABLE  = 8'h0A;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned BIT_ENABLE     = 7;
  localparam int unsigned BIT_SINGLE     = 6;
  localparam int unsigned BIT_TOUT       = 5;
  localparam int unsigned BIT_MASK       = 1;
  localparam int unsigned BIT_PIN        = 0;
  localparam int unsigned BIT_DEMOD      = 6;
  localparam int unsigned MODE_LSB       = 2;
  localparam int unsigned BIT_SHORT_INIT = 1;
  localparam int unsigned BIT_LONG_INIT  = 0;
  localparam int unsigned IRQ_SHORT      = 0;
  localparam int unsigned IRQ_LONG       = 1;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_PING = 2'h1;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [1:0] RST_PAIR  = 2'h0;

endpackage : adt_pkg

/* design/adt_reset_sync.sv */
// Reset release synchroniser.
// Assumes an asynchronous active-low reset from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module adt_reset_sync (
  // Clock and raw reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Synchronised reset
  output logic      rst_no
);
  logic meta_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= 1'b0;
      rst_no <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      rst_no <= meta_q;
    end
  end
endmodule : adt_reset_sync
`default_nettype wire

/* design/adt_timer.sv */
// Alternating dual timer: short and long counters with ping-pong hand-over.
// Assumes a single 40 MHz clock and a one-cycle strobed register port.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module adt_timer (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Timer outputs
  output logic            short_out_o,
  output logic            long_out_o,
  output logic            short_pin_en_o,
  output logic            long_pin_en_o,
  // Interrupt
  output logic            irq_o
);
  localparam int unsigned SW = adt_pkg::SHORT_W;
  localparam int unsigned LW = adt_pkg::LONG_W;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_n;

  adt_reset_sync u_rst (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .rst_no   (rst_n)
  );

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic          sc_single_q, sc_single_d;
  logic          sc_mask_q,   sc_mask_d;
  logic          sc_tout_q,   sc_tout_d;
  logic          lc_single_q, lc_single_d;
  logic          lc_mask_q,   lc_mask_d;
  logic          lc_tout_q,   lc_tout_d;
  logic    [1:0] mode_q,      mode_d;
  logic          demod_q,     demod_d;
  logic          sinit_q,     sinit_d;
  logic          linit_q,     linit_d;
  logic    [7:0] srl_lo_q,    srl_lo_d;
  logic    [7:0] srl_hi_q,    srl_hi_d;
  logic    [7:0] lrl_lo_q,    lrl_lo_d;
  logic    [7:0] lrl_hi_q,    lrl_hi_d;
  logic    [1:0] ist_q,       ist_d;
  logic    [1:0] ien_q,       ien_d;
  logic          sout_d,      lout_d;
  logic          spin_d,      lpin_d;
  logic          irq_d;
  logic    [7:0] rdata_d;

  // ****************************************************************
  // Decode and sequencing
  // ****************************************************************
  logic          wr_sc, wr_sh, wr_lc, wr_clr;
  logic          ping;
  logic          s_run, s_tc, l_run, l_tc;
  logic [SW-1:0] s_cnt;
  logic [LW-1:0] l_cnt;
  logic          s_start, s_stop, l_start, l_stop;
  logic          s_lvl;
  logic [SW-1:0] s_val;
  logic [LW-1:0] l_val;

  assign wr_sc  = wr_i && (addr_i == adt_pkg::ADR_SHORT_CTRL);
  assign wr_sh  = wr_i && (addr_i == adt_pkg::ADR_SHARED_CTRL);
  assign wr_lc  = wr_i && (addr_i == adt_pkg::ADR_LONG_CTRL);
  assign wr_clr = wr_i && (addr_i == adt_pkg::ADR_IRQ_CLEAR);

  // Hand-over needs ping-pong selected and transmit mode
  assign ping = (mode_q == adt_pkg::MODE_PING) && !demod_q;

  // Software enable or hand-over starts; hand-over stops the finisher
  assign s_start = (wr_sc && wdata_i[adt_pkg::BIT_ENABLE])
                 || (ping && l_tc);
  assign s_stop  = (wr_sc && !wdata_i[adt_pkg::BIT_ENABLE])
                 || (ping && s_tc);
  assign l_start = (wr_lc && wdata_i[adt_pkg::BIT_ENABLE])
                 || (ping && s_tc);
  assign l_stop  = (wr_lc && !wdata_i[adt_pkg::BIT_ENABLE])
                 || (ping && l_tc);

  // Level the short output takes with this load
  assign s_lvl = s_start ? sinit_q : !short_out_o;
  assign s_val = s_lvl ? srl_hi_q : srl_lo_q;
  assign l_val = {lrl_hi_q, lrl_lo_q};

  adt_counter #(
    .W (SW)
  ) u_short (
    .clk_i    (clk_i),
    .rst_ni   (rst_n),
    .start_i  (s_start),
    .stop_i   (s_stop),
    .single_i (sc_single_q),
    .value_i  (s_val),
    .run_o    (s_run),
    .tc_o     (s_tc),
    .count_o  (s_cnt)
  );

  adt_counter #(
    .W (LW)
  ) u_long (
    .clk_i    (clk_i),
    .rst_ni   (rst_n),
    .start_i  (l_start),
    .stop_i   (l_stop),
    .single_i (lc_single_q),
    .value_i  (l_val),
    .run_o    (l_run),
    .tc_o     (l_tc),
    .count_o  (l_cnt)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    sc_single_d = sc_single_q;
    sc_mask_d   = sc_mask_q;
    lc_single_d = lc_single_q;
    lc_mask_d   = lc_mask_q;
    mode_d      = mode_q;
    demod_d     = demod_q;
    sinit_d     = sinit_q;
    linit_d     = linit_q;
    srl_lo_d    = srl_lo_q;
    srl_hi_d    = srl_hi_q;
    lrl_lo_d    = lrl_lo_q;
    lrl_hi_d    = lrl_hi_q;
    ien_d       = ien_q;
    spin_d      = short_pin_en_o;
    lpin_d      = long_pin_en_o;
    if (wr_sc) begin
      sc_single_d = wdata_i[adt_pkg::BIT_SINGLE];
      sc_mask_d   = wdata_i[adt_pkg::BIT_MASK];
      spin_d      = wdata_i[adt_pkg::BIT_PIN];
    end
    if (wr_lc) begin
      lc_single_d = wdata_i[adt_pkg::BIT_SINGLE];
      lc_mask_d   = wdata_i[adt_pkg::BIT_MASK];
      lpin_d      = wdata_i[adt_pkg::BIT_PIN];
    end
    if (wr_sh) begin
      mode_d  = wdata_i[adt_pkg::MODE_LSB+1:adt_pkg::MODE_LSB];
      demod_d = wdata_i[adt_pkg::BIT_DEMOD];
      sinit_d = wdata_i[adt_pkg::BIT_SHORT_INIT];
      linit_d = wdata_i[adt_pkg::BIT_LONG_INIT];
    end
    if (wr_i && addr_i == adt_pkg::ADR_SRL_LO) srl_lo_d = wdata_i;
    if (wr_i && addr_i == adt_pkg::ADR_SRL_HI) srl_hi_d = wdata_i;
    if (wr_i && addr_i == adt_pkg::ADR_LRL_LO) lrl_lo_d = wdata_i;
    if (wr_i && addr_i == adt_pkg::ADR_LRL_HI) lrl_hi_d = wdata_i;
    if (wr_i && addr_i == adt_pkg::ADR_IRQ_ENABLE) ien_d = wdata_i[1:0];

    // Sticky flags, set beats a clear in the same cycle
    sc_tout_d = s_tc || (sc_tout_q
              && !(wr_sc && wdata_i[adt_pkg::BIT_TOUT]));
    lc_tout_d = l_tc || (lc_tout_q
              && !(wr_lc && wdata_i[adt_pkg::BIT_TOUT]));
    ist_d = {l_tc, s_tc}
          | (ist_q & ~(wr_clr ? wdata_i[1:0] : 2'h0));
    irq_d = |(ist_d & ien_q & {lc_mask_q, sc_mask_q});

    // Outputs take the initial level on start, toggle at terminal count
    sout_d = short_out_o;
    if (s_start && !s_stop) begin
      sout_d = sinit_q;
    end else if (s_tc) begin
      sout_d = !short_out_o;
    end
    lout_d = long_out_o;
    if (l_start && !l_stop) begin
      lout_d = linit_q;
    end else if (l_tc) begin
      lout_d = !long_out_o;
    end

    // Read data valid only in the cycle after the read strobe
    rdata_d = adt_pkg::RST_BYTE;
    if (rd_i) begin
      case (addr_i)
        adt_pkg::ADR_SHORT_CTRL:  rdata_d = {s_run, sc_single_q,
                                   sc_tout_q, 3'h0, sc_mask_q,
                                   short_pin_en_o};
        adt_pkg::ADR_SHARED_CTRL: rdata_d = {1'b0, demod_q, 2'h0,
                                   mode_q, sinit_q, linit_q};
        adt_pkg::ADR_LONG_CTRL:   rdata_d = {l_run, lc_single_q,
                                   lc_tout_q, 3'h0, lc_mask_q,
                                   long_pin_en_o};
        adt_pkg::ADR_SRL_LO:      rdata_d = srl_lo_q;
        adt_pkg::ADR_SRL_HI:      rdata_d = srl_hi_q;
        adt_pkg::ADR_LRL_LO:      rdata_d = lrl_lo_q;
        adt_pkg::ADR_LRL_HI:      rdata_d = lrl_hi_q;
        adt_pkg::ADR_IRQ_STATUS:  rdata_d = {6'h00, ist_q};
        adt_pkg::ADR_IRQ_ENABLE:  rdata_d = {6'h00, ien_q};
        default:                  rdata_d = adt_pkg::RST_BYTE;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sc_single_q    <= 1'b0;
      sc_mask_q      <= 1'b0;
      sc_tout_q      <= 1'b0;
      lc_single_q    <= 1'b0;
      lc_mask_q      <= 1'b0;
      lc_tout_q      <= 1'b0;
      mode_q         <= adt_pkg::MODE_OFF;
      demod_q        <= 1'b0;
      sinit_q        <= 1'b0;
      linit_q        <= 1'b0;
      srl_lo_q       <= adt_pkg::RST_BYTE;
      srl_hi_q       <= adt_pkg::RST_BYTE;
      lrl_lo_q       <= adt_pkg::RST_BYTE;
      lrl_hi_q       <= adt_pkg::RST_BYTE;
      ist_q          <= adt_pkg::RST_PAIR;
      ien_q          <= adt_pkg::RST_PAIR;
      short_out_o    <= 1'b0;
      long_out_o     <= 1'b0;
      short_pin_en_o <= 1'b0;
      long_pin_en_o  <= 1'b0;
      irq_o          <= 1'b0;
      rdata_o        <= adt_pkg::RST_BYTE;
    end else begin
      sc_single_q    <= sc_single_d;
      sc_mask_q      <= sc_mask_d;
      sc_tout_q      <= sc_tout_d;
      lc_single_q    <= lc_single_d;
      lc_mask_q      <= lc_mask_d;
      lc_tout_q      <= lc_tout_d;
      mode_q         <= mode_d;
      demod_q        <= demod_d;
      sinit_q        <= sinit_d;
      linit_q        <= linit_d;
      srl_lo_q       <= srl_lo_d;
      srl_hi_q       <= srl_hi_d;
      lrl_lo_q       <= lrl_lo_d;
      lrl_hi_q       <= lrl_hi_d;
      ist_q          <= ist_d;
      ien_q          <= ien_d;
      short_out_o    <= sout_d;
      long_out_o     <= lout_d;
      short_pin_en_o <= spin_d;
      long_pin_en_o  <= lpin_d;
      irq_o          <= irq_d;
      rdata_o        <= rdata_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  short_handover_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ping && s_tc && !wr_i) |=> (l_run && !s_run))
    else $error("short terminal count did not hand over to long");

  long_handover_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ping && l_tc && !wr_i) |=> (s_run && !l_run))
    else $error("long terminal count did not hand back to short");

  short_init_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (s_start && !s_stop) |=> (short_out_o == $past(sinit_q)))
    else $error("short output did not take its initial level");

  short_load_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (s_start && !s_stop) |=> (s_cnt == ($past(sinit_q)
      ? $past(srl_hi_q) : $past(srl_lo_q))))
    else $error("short counter loaded the wrong reload byte");

  long_start_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (l_start && !l_stop) |=> (long_out_o == $past(linit_q)
      && l_cnt == $past({lrl_hi_q, lrl_lo_q})))
    else $error("long counter start level or load wrong");

  timeout_flag_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (s_tc || (sc_tout_q && !(wr_sc && wdata_i[adt_pkg::BIT_TOUT])))
    |=> sc_tout_q)
    else $error("short timeout flag lost");

  independent_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (mode_q == adt_pkg::MODE_OFF && s_tc && !l_run && !wr_i)
    |=> !l_run)
    else $error("hand-over occurred with mode off");

  demod_block_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (demod_q && s_tc && !l_run && !wr_i) |=> !l_run)
    else $error("hand-over occurred in demodulation mode");

  irq_raise_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    ($rose(ist_q[adt_pkg::IRQ_SHORT]) && $past(sc_mask_q)
      && $past(ien_q[adt_pkg::IRQ_SHORT])) |-> irq_o)
    else $error("short terminal count interrupt not raised");
endmodule : adt_timer
`default_nettype wire

/* verif/tb_adt_timer.sv */
// Self-checking bench for the alternating dual timer.
// Assumes the timer top with its one-cycle strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tb_adt_timer;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       clk_i;
  logic       resetn_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       short_out_o;
  logic       long_out_o;
  logic       short_pin_en_o;
  logic       long_pin_en_o;
  logic       irq_o;
  int         error_cnt;
  int         n_compared;
  int         n;
  int         i;
  logic       lvl;
  logic [7:0] shv [2] = '{8'h00, 8'h44};

  adt_timer adt_timer_i (
    .clk_i          (clk_i),
    .resetn_i       (resetn_i),
    .addr_i         (addr_i),
    .wdata_i        (wdata_i),
    .wr_i           (wr_i),
    .rd_i           (rd_i),
    .rdata_o        (rdata_o),
    .short_out_o    (short_out_o),
    .long_out_o     (long_out_o),
    .short_pin_en_o (short_pin_en_o),
    .long_pin_en_o  (long_pin_en_o),
    .irq_o          (irq_o)
  );

  always #12.5 clk_i = ~clk_i;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk("rdata", {8'h00, rdata_o}, {8'h00, exp});
  endtask : rd_chk

  // Edges until the chosen output toggles; first level in lvl
  task automatic wait_tog(input logic which);
    #1;
    lvl = which ? long_out_o : short_out_o;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while ((which ? long_out_o : short_out_o) === lvl && n < 600);
    if (n >= 600) error_cnt++;
  endtask : wait_tog

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    repeat (6000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    clk_i      = 1'b0;
    resetn_i   = 1'b0;
    addr_i     = 8'h00;
    wdata_i    = 8'h00;
    wr_i       = 1'b0;
    rd_i       = 1'b0;
    error_cnt  = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    // Reset values, unmapped and write-only places read zero
    for (i = 0; i < 16; i++) begin
      rd_chk(i[7:0], adt_pkg::RST_BYTE);
    end
    chk("irq", {15'h0000, irq_o}, 16'h0000);
    // Reload registers, unmapped write ignored
    wr(adt_pkg::ADR_SRL_LO, 8'h09);
    wr(adt_pkg::ADR_SRL_HI, 8'h04);
    wr(adt_pkg::ADR_LRL_LO, 8'h03);
    wr(adt_pkg::ADR_LRL_HI, 8'h01);
    wr(8'h03, 8'hFF);
    rd_chk(adt_pkg::ADR_SRL_LO, 8'h09);
    rd_chk(adt_pkg::ADR_SRL_HI, 8'h04);
    rd_chk(adt_pkg::ADR_LRL_LO, 8'h03);
    rd_chk(adt_pkg::ADR_LRL_HI, 8'h01);
    rd_chk(8'h03, 8'h00);
    // Mode off, then demodulation: no hand-over, single pass halts
    for (i = 0; i < 2; i++) begin
      wr(adt_pkg::ADR_SHARED_CTRL, shv[i]);
      wr(adt_pkg::ADR_SHORT_CTRL, 8'hC2);
      repeat (20) @(posedge clk_i);
      wr(adt_pkg::ADR_SHORT_CTRL, 8'h42);
      rd_chk(adt_pkg::ADR_SHORT_CTRL, 8'h62);
      rd_chk(adt_pkg::ADR_LONG_CTRL, 8'h00);
      rd_chk(adt_pkg::ADR_IRQ_STATUS, 8'h01);
      chk("irq", {15'h0000, irq_o}, 16'h0000);
      wr(adt_pkg::ADR_SHORT_CTRL, 8'h62);
      rd_chk(adt_pkg::ADR_SHORT_CTRL, 8'h42);
      wr(adt_pkg::ADR_IRQ_CLEAR, 8'h01);
      rd_chk(adt_pkg::ADR_IRQ_STATUS, 8'h00);
    end
    // Ping-pong started from the short counter
    wr(adt_pkg::ADR_IRQ_ENABLE, 8'h03);
    wr(adt_pkg::ADR_LONG_CTRL, 8'h42);
    wr(adt_pkg::ADR_SHARED_CTRL, 8'h07);
    rd_chk(adt_pkg::ADR_SHARED_CTRL, 8'h07);
    wr(adt_pkg::ADR_SHORT_CTRL, 8'hC2);
    wait_tog(1'b0);
    chk("short init", {15'h0000, lvl}, 16'h0001);
    chk("short span", n[15:0], 16'h0004);
    chk("long init", {15'h0000, long_out_o}, 16'h0001);
    wait_tog(1'b1);
    chk("long span", n[15:0], 16'h0103);
    chk("short again", {15'h0000, short_out_o}, 16'h0001);
    chk("irq", {15'h0000, irq_o}, 16'h0001);
    wait_tog(1'b0);
    chk("short span", n[15:0], 16'h0004);
    chk("long again", {15'h0000, long_out_o}, 16'h0001);
    // Mode field cleared while long counter runs
    wr(adt_pkg::ADR_SHARED_CTRL, 8'h03);
    wait_tog(1'b1);
    repeat (12) @(posedge clk_i);
    #1;
    chk("short held", {15'h0000, short_out_o}, 16'h0000);
    rd_chk(adt_pkg::ADR_SHORT_CTRL, 8'h62);
    rd_chk(adt_pkg::ADR_IRQ_STATUS, 8'h03);
    wr(adt_pkg::ADR_IRQ_CLEAR, 8'h03);
    wr(adt_pkg::ADR_SHORT_CTRL, 8'h62);
    wr(adt_pkg::ADR_LONG_CTRL, 8'h62);
    rd_chk(adt_pkg::ADR_IRQ_STATUS, 8'h00);
    chk("irq", {15'h0000, irq_o}, 16'h0000);
    // Ping-pong started from the long counter
    wr(adt_pkg::ADR_SHARED_CTRL, 8'h07);
    wr(adt_pkg::ADR_LONG_CTRL, 8'hC2);
    wait_tog(1'b1);
    chk("long init", {15'h0000, lvl}, 16'h0001);
    chk("long span", n[15:0], 16'h0103);
    chk("short start", {15'h0000, short_out_o}, 16'h0001);
    wr(adt_pkg::ADR_SHARED_CTRL, 8'h00);
    wr(adt_pkg::ADR_SHORT_CTRL, 8'h20);
    // Free-running short counter alternates low and high reloads
    wr(adt_pkg::ADR_LONG_CTRL, 8'h21);
    rd_chk(adt_pkg::ADR_LONG_CTRL, 8'h01);
    chk("long pin", {15'h0000, long_pin_en_o}, 16'h0001);
    wr(adt_pkg::ADR_SHORT_CTRL, 8'h81);
    wait_tog(1'b0);
    chk("short lo span", n[15:0], 16'h0009);
    chk("short pin", {15'h0000, short_pin_en_o}, 16'h0001);
    wait_tog(1'b0);
    chk("short hi span", n[15:0], 16'h0004);
    rd_chk(adt_pkg::ADR_IRQ_STATUS, 8'h03);
    chk("irq", {15'h0000, irq_o}, 16'h0000);
    wr(adt_pkg::ADR_SHORT_CTRL, 8'h20);
    report_and_stop();
  end
endmodule : tb_adt_timer
`default_nettype wire
